// File: cmf_pkg.sv
// Constants, offsets and enumerations for the CAN message filter/formatter
package cmf_pkg;
  // APB register byte addresses
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_FILT_L = 8'h04;
  localparam logic [7:0] OFS_FILT_S = 8'h08;
  localparam logic [7:0] OFS_MASK_L = 8'h0C;
  localparam logic [7:0] OFS_MASK_S = 8'h10;
  localparam logic [7:0] OFS_PRIO = 8'h14;
  localparam logic [7:0] OFS_HDR = 8'h18;
  localparam logic [7:0] OFS_TXD_HI = 8'h1C;
  localparam logic [7:0] OFS_TXD_LO = 8'h20;
  localparam logic [7:0] OFS_TX_CMD = 8'h24;
  localparam logic [7:0] OFS_COUNT = 8'h28;
  // Control and count register field positions
  localparam int CTRL_FMT = 0;
  localparam int CTRL_FLOW = 1;
  localparam int CTRL_HDR = 2;
  localparam int CTRL_EXT = 3;
  localparam int CTRL_MON = 4;
  localparam int CNT_DROP = 16;
  // Widths
  localparam int ID_W = 29;
  localparam int SHORT_W = 11;
  localparam int PRIO_W = 5;
  localparam int HDR_W = 24;
  localparam int CNT_W = 16;
  localparam int BYTES = 8;
  // Reset values
  localparam logic [4:0] RST_PRIO = 5'h18;
  localparam logic RST_FMT = 1'b1;
  localparam logic RST_FLOW = 1'b1;
  localparam logic [28:0] RST_FILT = 29'h0000_0000;
  localparam logic [28:0] RST_MASK = 29'h0000_0000;
  // Protocol control byte encodings
  localparam logic [3:0] PCI_SF = 4'h0;
  localparam logic [3:0] PCI_FF = 4'h1;
  localparam logic [3:0] PCI_CF = 4'h2;
  localparam logic [3:0] PCI_FC = 4'h3;
  localparam logic [3:0] SF_MAX = 4'h7;
  localparam logic [3:0] FF_SEG_LEN = 4'h6;
  localparam logic [3:0] DLC_FULL = 4'h8;
  localparam logic [3:0] FC_MIN_DLC = 4'h3;
  localparam logic [11:0] FF_MIN = 12'h008;
  localparam logic [7:0] FILL = 8'h00;
  localparam logic [7:0] FC_BYTE0 = 8'h30;
  localparam logic [28:0] SHORT_FC_OFS = 29'h0000_0008;
  // Monitoring modes
  typedef enum logic [1:0] {
    MON_NONE = 2'b00,
    MON_ALL = 2'b01,
    MON_RX = 2'b10,
    MON_TX = 2'b11
  } cmf_mon_t;
  // Kinds of output line
  typedef enum logic [2:0] {
    K_DATA = 3'b000,
    K_DATA_ERR = 3'b001,
    K_RTR = 3'b010,
    K_TOTAL = 3'b011,
    K_SEG = 3'b100
  } cmf_kind_t;
  // Output sequencer states
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_SEG = 1'b1
  } cmf_state_t;
endpackage

// File: cmf_top.sv
// CAN receive filter, auto formatting and flow control reply engine
//
// Behaviour
// - Accept frame only where masked bits match filter
// - Short filter keeps 11 bits, upper zeroed
// - Long filter keeps 29 bits, top three ignored
// - Short and long filter share one storage
// - Short mask keeps low 11 bits only
// - Masks share one right-justified storage
// - Long mask keeps 29 bits
// - Priority gives top five bits of 29-bit host transmit ids
// - Priority resets to hex 18
// - Formatting adds/strips control bytes, drops bad
// - Monitoring shows bad frames with error marker
// - Multi-frame: total line, then numbered segments
// - First Frame triggers Flow Control reply
// - Flow control replies switchable, default on
// - No Flow Control while monitoring
// - Remote frames hidden when formatting, else shown
// - Raw mode: bytes unaltered, pad to eight
// - Header display shows raw, transmit still formatted
// - Formatting enabled after reset
//
// Added by the designer: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
module cmf_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_valid,
  output logic rx_ready,
  input wire logic [28:0] rx_id,
  input wire logic rx_ext,
  input wire logic rx_rtr,
  input wire logic [3:0] rx_dlc,
  input wire logic [63:0] rx_data,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [28:0] tx_id,
  output logic tx_ext,
  output logic [63:0] tx_data,
  output logic out_valid,
  output logic [2:0] out_kind,
  output logic [28:0] out_id,
  output logic [3:0] out_len,
  output logic [3:0] out_seg,
  output logic [11:0] out_total,
  output logic [63:0] out_data,
  output logic fc_sent
);

  // Whole module state
  typedef struct packed {
    logic fmt;                  // Automatic formatting
    logic flow;                 // Automatic flow control replies
    logic hdr_disp;             // Header display
    logic tx_ext;               // Host frames use 29-bit ids
    cmf_pkg::cmf_mon_t mon;     // Monitoring mode
    logic [28:0] filt;          // Shared filter storage
    logic [28:0] mask;          // Shared mask storage
    logic [4:0] prio;           // Priority bits
    logic [23:0] hdr;           // Transmit header
    logic [63:0] txd;           // Host transmit bytes, byte 0 on top
    logic [3:0] tx_len;         // Host byte count
    logic tx_pend;              // Host frame waiting
    logic fc_pend;              // Flow control reply waiting
    logic [28:0] fc_id;         // Id for the reply
    logic fc_ext;
    logic tx_valid;
    logic [28:0] tx_id;
    logic txo_ext;
    logic [63:0] tx_data;
    logic fc_sent;
    cmf_pkg::cmf_state_t st;
    logic [63:0] seg_data;      // First Frame segment held back
    logic out_valid;
    cmf_pkg::cmf_kind_t out_kind;
    logic [28:0] out_id;
    logic [3:0] out_len;
    logic [3:0] out_seg;
    logic [11:0] out_total;
    logic [63:0] out_data;
    logic [15:0] acc_cnt;       // Frames accepted
    logic [15:0] drop_cnt;      // Frames discarded by filter
    logic [31:0] prdata;
    logic first;                // High for the cycle after reset
  } cmf_state_all_t;

  cmf_state_all_t st_r;
  cmf_state_all_t st_nxt;

  // Bus decode and receive helpers, visible to the checks
  logic acc_ph;
  logic wr_en;
  logic rx_take;
  logic id_match;
  logic pci_ok;
  logic [3:0] pci_t;
  logic [28:0] fc_id_calc;
  logic raw_rx;
  logic map_hit;
  logic fc_req;

  // Checks a received control byte against the frame length
  function automatic logic pci_valid(input logic [63:0] d,
                                     input logic [3:0] dlc);
    logic [3:0] l;
    logic [11:0] tot;
    l = d[59:56];
    tot = d[59:48];
    case (d[63:60])
      cmf_pkg::PCI_SF: pci_valid = (l != 4'h0) && (l <= cmf_pkg::SF_MAX)
                                   && (l < dlc);
      cmf_pkg::PCI_FF: pci_valid = (dlc == cmf_pkg::DLC_FULL)
                                   && (tot >= cmf_pkg::FF_MIN);
      cmf_pkg::PCI_CF: pci_valid = (dlc != 4'h0);
      cmf_pkg::PCI_FC: pci_valid = (dlc >= cmf_pkg::FC_MIN_DLC);
      default: pci_valid = 1'b0;
    endcase
  endfunction

  // Replaces every byte from position n onward with the filler
  function automatic logic [63:0] pad(input logic [63:0] d,
                                      input logic [3:0] n);
    logic [63:0] r;
    r = d;
    for (int i = 0; i < cmf_pkg::BYTES; i++) begin
      if (4'(i) >= n) begin
        r[63 - 8 * i -: 8] = cmf_pkg::FILL;
      end
    end
    return r;
  endfunction

  // APB decode; the slave never waits, so access and answer coincide
  assign acc_ph = psel && penable;
  assign wr_en = acc_ph && pwrite;
  always_comb begin
    case (paddr)
      cmf_pkg::OFS_CTRL, cmf_pkg::OFS_FILT_L, cmf_pkg::OFS_FILT_S,
      cmf_pkg::OFS_MASK_L, cmf_pkg::OFS_MASK_S, cmf_pkg::OFS_PRIO,
      cmf_pkg::OFS_HDR, cmf_pkg::OFS_TXD_HI, cmf_pkg::OFS_TXD_LO,
      cmf_pkg::OFS_TX_CMD, cmf_pkg::OFS_COUNT: map_hit = 1'b1;
      default: map_hit = 1'b0;
    endcase
  end

  // Receive side helpers
  assign rx_take = rx_valid && rx_ready;
  // Short ids arrive right-justified, so one comparator serves both
  assign id_match = ((rx_id ^ st_r.filt) & st_r.mask) == 29'h0000_0000;
  assign pci_ok = pci_valid(rx_data, rx_dlc);
  assign pci_t = rx_data[63:60];
  // Header display overrides receive formatting only
  assign raw_rx = !st_r.fmt || st_r.hdr_disp;
  // Reply id: 11-bit answers 8 below, 29-bit swaps the address bytes
  assign fc_id_calc = rx_ext ? {rx_id[28:16], rx_id[7:0], rx_id[15:8]}
                             : (rx_id - cmf_pkg::SHORT_FC_OFS);
  // Valid First Frame wants a reply, never while monitoring
  assign fc_req = rx_take && id_match && !rx_rtr && pci_ok
                  && pci_t == cmf_pkg::PCI_FF && st_r.flow
                  && st_r.mon == cmf_pkg::MON_NONE;

  // Next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.out_valid = 1'b0;
    st_nxt.fc_sent = 1'b0;
    st_nxt.first = 1'b0;

    // Register writes take effect in the access phase
    if (wr_en) begin
      case (paddr)
        cmf_pkg::OFS_CTRL: begin
          st_nxt.fmt = pwdata[cmf_pkg::CTRL_FMT];
          st_nxt.flow = pwdata[cmf_pkg::CTRL_FLOW];
          st_nxt.hdr_disp = pwdata[cmf_pkg::CTRL_HDR];
          st_nxt.tx_ext = pwdata[cmf_pkg::CTRL_EXT];
          st_nxt.mon = cmf_pkg::cmf_mon_t'(pwdata[cmf_pkg::CTRL_MON +: 2]);
        end
        // Long form drops the three top bits
        cmf_pkg::OFS_FILT_L: st_nxt.filt = pwdata[28:0];
        // Short form keeps 11 bits and clears the rest
        cmf_pkg::OFS_FILT_S: st_nxt.filt = {18'h0_0000,
                                            pwdata[10:0]};
        cmf_pkg::OFS_MASK_L: st_nxt.mask = pwdata[28:0];
        cmf_pkg::OFS_MASK_S: st_nxt.mask = {18'h0_0000,
                                            pwdata[10:0]};
        cmf_pkg::OFS_PRIO: st_nxt.prio = pwdata[4:0];
        cmf_pkg::OFS_HDR: st_nxt.hdr = pwdata[23:0];
        cmf_pkg::OFS_TXD_HI: st_nxt.txd[63:32] = pwdata;
        cmf_pkg::OFS_TXD_LO: st_nxt.txd[31:0] = pwdata;
        cmf_pkg::OFS_TX_CMD: begin
          // A send request while one waits is ignored
          if (!st_r.tx_pend) begin
            st_nxt.tx_pend = 1'b1;
            st_nxt.tx_len = pwdata[3:0];
          end
        end
        default: ;
      endcase
    end

    // Read data is latched in the setup phase so it comes from a flop
    if (psel && !penable && !pwrite) begin
      case (paddr)
        cmf_pkg::OFS_CTRL: st_nxt.prdata = {26'h000_0000, st_r.mon,
                                            st_r.tx_ext, st_r.hdr_disp,
                                            st_r.flow, st_r.fmt};
        cmf_pkg::OFS_FILT_L, cmf_pkg::OFS_FILT_S:
          st_nxt.prdata = {3'h0, st_r.filt};
        cmf_pkg::OFS_MASK_L, cmf_pkg::OFS_MASK_S:
          st_nxt.prdata = {3'h0, st_r.mask};
        cmf_pkg::OFS_PRIO: st_nxt.prdata = {27'h000_0000, st_r.prio};
        cmf_pkg::OFS_HDR: st_nxt.prdata = {8'h00, st_r.hdr};
        cmf_pkg::OFS_TXD_HI: st_nxt.prdata = st_r.txd[63:32];
        cmf_pkg::OFS_TXD_LO: st_nxt.prdata = st_r.txd[31:0];
        cmf_pkg::OFS_TX_CMD: st_nxt.prdata = {26'h000_0000, st_r.fc_pend,
                                              st_r.tx_pend, st_r.tx_len};
        cmf_pkg::OFS_COUNT: st_nxt.prdata = {st_r.drop_cnt, st_r.acc_cnt};
        default: st_nxt.prdata = 32'h0000_0000;
      endcase
    end

    // Output sequencer: second line of a First Frame
    case (st_r.st)
      cmf_pkg::ST_SEG: begin
        st_nxt.out_valid = 1'b1;
        st_nxt.out_kind = cmf_pkg::K_SEG;
        st_nxt.out_seg = 4'h0;
        st_nxt.out_len = cmf_pkg::FF_SEG_LEN;
        st_nxt.out_data = st_r.seg_data;
        st_nxt.st = cmf_pkg::ST_IDLE;
      end
      default: begin
        if (rx_take) begin
          if (!id_match) begin
            // Discarded by the filter
            st_nxt.drop_cnt = st_r.drop_cnt + 16'h0001;
          end else begin
            st_nxt.acc_cnt = st_r.acc_cnt + 16'h0001;
            st_nxt.out_id = rx_id;
            st_nxt.out_data = rx_data;
            st_nxt.out_len = rx_dlc;
            st_nxt.out_seg = 4'h0;
            st_nxt.out_total = 12'h000;
            // Flow control reply, whatever the formatting mode
            if (fc_req) begin
              st_nxt.fc_pend = 1'b1;
              st_nxt.fc_id = fc_id_calc;
              st_nxt.fc_ext = rx_ext;
            end
            if (rx_rtr) begin
              // Remote frames carry no data: hidden when formatting
              if (!st_r.fmt) begin
                st_nxt.out_valid = 1'b1;
                st_nxt.out_kind = cmf_pkg::K_RTR;
                st_nxt.out_len = 4'h0;
              end
            end else if (st_r.fmt && !pci_ok) begin
              // Bad control byte: shown only while monitoring
              if (st_r.mon != cmf_pkg::MON_NONE) begin
                st_nxt.out_valid = 1'b1;
                st_nxt.out_kind = cmf_pkg::K_DATA_ERR;
              end
            end else if (raw_rx) begin
              // Every byte as received
              st_nxt.out_valid = 1'b1;
              st_nxt.out_kind = cmf_pkg::K_DATA;
            end else begin
              st_nxt.out_valid = 1'b1;
              case (pci_t)
                cmf_pkg::PCI_SF: begin
                  // Strip the control byte and trailing unused bytes
                  st_nxt.out_kind = cmf_pkg::K_DATA;
                  st_nxt.out_len = rx_data[59:56];
                  st_nxt.out_data = pad({rx_data[55:0], cmf_pkg::FILL},
                                        rx_data[59:56]);
                end
                cmf_pkg::PCI_FF: begin
                  // Total length first, segment 0 next cycle
                  st_nxt.out_kind = cmf_pkg::K_TOTAL;
                  st_nxt.out_total = rx_data[59:48];
                  st_nxt.out_len = 4'h0;
                  st_nxt.seg_data = {rx_data[47:0], 16'h0000};
                  st_nxt.st = cmf_pkg::ST_SEG;
                end
                cmf_pkg::PCI_CF: begin
                  st_nxt.out_kind = cmf_pkg::K_SEG;
                  st_nxt.out_seg = rx_data[59:56];
                  st_nxt.out_len = rx_dlc - 4'h1;
                  st_nxt.out_data = {rx_data[55:0], cmf_pkg::FILL};
                end
                default: begin
                  // Flow control seen from the far end: shown as is
                  st_nxt.out_kind = cmf_pkg::K_DATA;
                end
              endcase
            end
          end
        end
      end
    endcase

    // Transmit engine: a waiting reply goes before host frames
    if (st_r.tx_valid && tx_ready) begin
      st_nxt.tx_valid = 1'b0;
    end else if (!st_r.tx_valid) begin
      if (st_r.fc_pend) begin
        st_nxt.fc_pend = fc_req; // A reply due now stays queued
        st_nxt.fc_sent = 1'b1;
        st_nxt.tx_valid = 1'b1;
        st_nxt.tx_id = st_r.fc_id;
        st_nxt.txo_ext = st_r.fc_ext;
        st_nxt.tx_data = pad({cmf_pkg::FC_BYTE0, 56'h0}, 4'h3);
      end else if (st_r.tx_pend) begin
        st_nxt.tx_pend = 1'b0;
        st_nxt.tx_valid = 1'b1;
        st_nxt.txo_ext = st_r.tx_ext;
        // Priority on top of the 24 header bits
        st_nxt.tx_id = st_r.tx_ext ? {st_r.prio, st_r.hdr}
                                   : {18'h0_0000, st_r.hdr[10:0]};
        if (st_r.fmt) begin
          // Single-frame control byte, then padding to eight
          st_nxt.tx_data = pad({4'h0, (st_r.tx_len > cmf_pkg::SF_MAX)
                                ? cmf_pkg::SF_MAX : st_r.tx_len,
                                st_r.txd[63:8]},
                               ((st_r.tx_len > cmf_pkg::SF_MAX)
                                ? cmf_pkg::SF_MAX : st_r.tx_len)
                               + 4'h1);
        end else begin
          st_nxt.tx_data = pad(st_r.txd, st_r.tx_len);
        end
      end
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
      st_r.fmt <= cmf_pkg::RST_FMT;
      st_r.flow <= cmf_pkg::RST_FLOW;
      st_r.prio <= cmf_pkg::RST_PRIO;
      st_r.filt <= cmf_pkg::RST_FILT;
      st_r.mask <= cmf_pkg::RST_MASK;
      st_r.first <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs
  assign prdata = st_r.prdata;
  assign pready = 1'b1;
  assign pslverr = acc_ph && !map_hit;
  assign rx_ready = (st_r.st == cmf_pkg::ST_IDLE);
  assign tx_valid = st_r.tx_valid;
  assign tx_id = st_r.tx_id;
  assign tx_ext = st_r.txo_ext;
  assign tx_data = st_r.tx_data;
  assign out_valid = st_r.out_valid;
  assign out_kind = st_r.out_kind;
  assign out_id = st_r.out_id;
  assign out_len = st_r.out_len;
  assign out_seg = st_r.out_seg;
  assign out_total = st_r.out_total;
  assign out_data = st_r.out_data;
  assign fc_sent = st_r.fc_sent;

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_ff_taken;
    rx_take && id_match && !rx_rtr && pci_ok && pci_t == cmf_pkg::PCI_FF;
  endsequence
  sequence s_total_line;
    out_valid && out_kind == cmf_pkg::K_TOTAL;
  endsequence
  sequence s_seg0_line;
    out_valid && out_kind == cmf_pkg::K_SEG && out_seg == 4'h0;
  endsequence

  a_filter_drop: assert property (rx_take && !id_match |=>
    st_r.drop_cnt == $past(st_r.drop_cnt) + 16'h0001 && !out_valid)
    else $error("mismatching frame not discarded");
  a_short_filter: assert property (wr_en && paddr == cmf_pkg::OFS_FILT_S
    |=> st_r.filt == {18'h0_0000, $past(pwdata[10:0])})
    else $error("short filter not right-justified");
  a_long_filter: assert property (wr_en && paddr == cmf_pkg::OFS_FILT_L
    |=> st_r.filt == $past(pwdata[28:0]))
    else $error("long filter not stored as 29 bits");
  a_short_mask: assert property (wr_en && paddr == cmf_pkg::OFS_MASK_S
    |=> st_r.mask[28:11] == 18'h0_0000)
    else $error("short mask upper bits not cleared");
  a_long_mask: assert property (wr_en && paddr == cmf_pkg::OFS_MASK_L
    |=> st_r.mask == $past(pwdata[28:0]))
    else $error("long mask not stored as 29 bits");
  a_prio_top_bits: assert property ($rose(tx_valid) && !fc_sent
    && tx_ext |-> tx_id[28:24] == st_r.prio)
    else $error("priority bits missing from transmit id");
  a_prio_reset: assert property (st_r.first |->
    st_r.prio == cmf_pkg::RST_PRIO && st_r.fmt && st_r.flow)
    else $error("wrong defaults after reset");
  a_ff_fc_reply: assert property ((s_ff_taken and (st_r.flow
    && st_r.mon == cmf_pkg::MON_NONE)) |-> ##[1:300] fc_sent)
    else $error("no flow control after first frame");
  a_mon_no_fc: assert property (st_r.mon != cmf_pkg::MON_NONE
    && !st_r.fc_pend |=> !st_r.fc_pend)
    else $error("flow control queued while monitoring");
  a_total_then_seg: assert property (s_total_line |=> s_seg0_line)
    else $error("segment 0 did not follow total length");
  a_rtr_hidden: assert property (rx_take && id_match && rx_rtr
    |=> out_valid == !$past(st_r.fmt))
    else $error("remote frame display wrong");

endmodule // cmf_top

// File: cmf_ecu.sv
// Behavioural model of the CAN control units beyond the block
`timescale 1ns/10ps
module cmf_ecu (
  input wire logic pclk,
  input wire logic presetn,
  output logic rx_valid,
  input wire logic rx_ready,
  output logic [28:0] rx_id,
  output logic rx_ext,
  output logic rx_rtr,
  output logic [3:0] rx_dlc,
  output logic [63:0] rx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [28:0] tx_id,
  input wire logic tx_ext,
  input wire logic [63:0] tx_data
);
  int stall = 0; // Cycles a sent frame waits before it is taken
  int wait_n; // Cycles waited on the present frame
  logic [93:0] txq[$]; // Frames taken off the block, oldest first

  // Quiet bus at time zero
  initial begin
    rx_valid = 1'h0;
    rx_id = 29'h0;
    rx_ext = 1'h0;
    rx_rtr = 1'h0;
    rx_dlc = 4'h0;
    rx_data = 64'h0;
  end

  // Offer one frame and hold it until the block takes it
  task automatic send(input logic [28:0] id, input logic ext,
    input logic rtr, input logic [3:0] dlc, input logic [63:0] d);
    int n;
    @(posedge pclk);
    rx_valid <= 1'h1;
    rx_id <= id;
    rx_ext <= ext;
    rx_rtr <= rtr;
    rx_dlc <= dlc;
    rx_data <= d;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (rx_ready !== 1'h1 && n < 50);
    if (n >= 50) testbench.n_mismatch++;
    rx_valid <= 1'h0;
    // Stale lines are inverted so no old frame can be mistaken for new
    rx_data <= ~d;
    rx_id <= ~id;
  endtask

  // Take transmitted frames, at once or after a stall
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_ready <= 1'h0;
      wait_n <= 0;
    end else if (tx_valid && tx_ready) begin
      txq.push_back({tx_ext, tx_id, tx_data});
      tx_ready <= 1'h0;
      wait_n <= 0;
    end else if (tx_valid) begin
      wait_n <= wait_n + 1;
      tx_ready <= (wait_n >= stall);
    end
  end
endmodule // cmf_ecu

// File: cmf_tb.sv
// Self-checking bench with reference model of filtering and formatting
`timescale 1ns/10ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_mismatch++; \
  $display("[FAIL] t=%0t got %h exp %h", $time, (a), (b)); end end
module testbench;
  // One expected output line
  typedef struct packed {
    logic [28:0] i;
    logic [2:0] k;
    logic [3:0] l;
    logic [3:0] s;
    logic [11:0] t;
    logic [63:0] d;
  } cmf_exp_t;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
  logic pwrite = 1'h0, pready, pslverr, rx_valid, rx_ready, rx_ext;
  logic rx_rtr, tx_valid, tx_ready, tx_ext, out_valid, fc_sent;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [28:0] rx_id, tx_id, out_id, filt = 29'h0, mask = 29'h0, id, cid;
  logic [3:0] rx_dlc, out_len, out_seg, dlc, ln;
  logic [63:0] rx_data, tx_data, out_data, hb, d;
  logic [2:0] out_kind;
  logic [11:0] out_total;
  logic fmt, flow, hdr, err;
  logic [1:0] mon;
  int n_mismatch = 0, n_tests = 0, seed = 32'hb5a737a0;
  int drops = 0, fcs = 0, fc_exp = 0;
  cmf_exp_t q[$], e; // Lines the model expects, in order

  cmf_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .rx_valid, .rx_ready, .rx_id, .rx_ext,
    .rx_rtr, .rx_dlc, .rx_data, .tx_valid, .tx_ready, .tx_id, .tx_ext,
    .tx_data, .out_valid, .out_kind, .out_id, .out_len, .out_seg,
    .out_total, .out_data, .fc_sent);
  cmf_ecu ecu (.pclk, .presetn, .rx_valid, .rx_ready, .rx_id, .rx_ext,
    .rx_rtr, .rx_dlc, .rx_data, .tx_valid, .tx_ready, .tx_id, .tx_ext,
    .tx_data);

  always #5 pclk = ~pclk; // 100 MHz

  // Leading bytes that a line of length l carries
  function automatic logic [63:0] mk(input logic [3:0] l);
    return (l == 4'h0) ? 64'h0 : ~64'h0 << (8 * (8 - l));
  endfunction

  // APB transfer: setup, then access held until pready
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 100);
    if (n >= 100) n_mismatch++;
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  // Read back one register and compare
  task automatic chkr(input logic [7:0] a, input logic [31:0] x);
    apb(1'h0, a, 32'h0);
    `CHK(rd, x)
  endtask

  // Set control fields in the bench and the block alike
  task automatic ctrl(input logic f, fl, h, ex, input logic [1:0] m);
    fmt = f;
    flow = fl;
    hdr = h;
    mon = m;
    apb(1'h1, cmf_pkg::OFS_CTRL, {26'h000_0000, m, ex, h, fl, f});
  endtask

  task automatic put(input logic [2:0] k, input logic [3:0] l,
    input logic [11:0] t, input logic [63:0] x);
    q.push_back({cid, k, l, 4'h0, t, x});
  endtask

  // Reference model for one received frame, then send it
  task automatic rx(input logic [28:0] i, input logic rtr,
    input logic [3:0] c, input logic [63:0] x);
    logic [3:0] ty;
    ty = x[63:60];
    cid = i;
    if (((i ^ filt) & mask) != 29'h0) drops++;
    else if (rtr) begin
      if (!fmt) put(cmf_pkg::K_RTR, 4'h0, 12'h0, 64'h0);
    end else begin
      if (ty == 4'h1 && c == 4'h8 && x[59:48] >= 12'h8 && flow
          && mon == 2'h0) fc_exp++;
      if (!fmt || hdr && ty <= 4'h1) put(cmf_pkg::K_DATA, c, 12'h0, x);
      else if (ty == 4'h0) put(cmf_pkg::K_DATA, x[59:56], 12'h0, x << 8);
      else if (ty == 4'h1) begin
        put(cmf_pkg::K_TOTAL, 4'h0, x[59:48], 64'h0);
        put(cmf_pkg::K_SEG, 4'h6, 12'h0, x << 16);
      end else if (mon != 2'h0) put(cmf_pkg::K_DATA_ERR, c, 12'h0, x);
    end
    ecu.send(i, 1'h0, rtr, c, x);
  endtask

  // Wait a bounded time for one frame on the bus and compare it
  task automatic txchk(input logic [93:0] x);
    int n;
    n = 0;
    while (ecu.txq.size() == 0 && n < 300) begin
      @(posedge pclk);
      n++;
    end
    `CHK((n < 300) ? ecu.txq.pop_front() : 94'h0, x)
  endtask

  // Every printed line is checked against the model's queue
  always @(posedge pclk) begin
    if (fc_sent === 1'h1) fcs++;
    if (out_valid === 1'h1) begin
      e = (q.size() > 0) ? q.pop_front() : '0;
      `CHK(out_kind, e.k)
      `CHK(out_id, e.i)
      if (e.k == cmf_pkg::K_TOTAL) `CHK(out_total, e.t)
      else if (e.k != cmf_pkg::K_RTR) begin
        `CHK(out_len, e.l)
        `CHK(out_data & mk(e.l), e.d & mk(e.l))
        `CHK(out_seg, e.s)
      end
    end
  end

  // Counts, verdict and the end of the run
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // A hang counts as a mismatch
  initial begin
    #400000;
    n_mismatch++;
    give_verdict();
  end

  // Main sequence
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'h1;
    chkr(cmf_pkg::OFS_CTRL, 32'h0000_0003);
    chkr(cmf_pkg::OFS_PRIO, 32'h0000_0018);
    chkr(cmf_pkg::OFS_MASK_L, 32'h0000_0000);
    apb(1'h0, 8'h2C, 32'h0);
    `CHK({err, rd}, 33'h1_0000_0000)
    $display("test reset values done");
    apb(1'h1, cmf_pkg::OFS_FILT_S, 32'hFFFF_FFFF);
    chkr(cmf_pkg::OFS_FILT_L, 32'h0000_07FF);
    apb(1'h1, cmf_pkg::OFS_FILT_L, 32'hFFFF_FFFF);
    chkr(cmf_pkg::OFS_FILT_S, 32'h1FFF_FFFF);
    apb(1'h1, cmf_pkg::OFS_MASK_S, 32'h0000_FFFF);
    chkr(cmf_pkg::OFS_MASK_L, 32'h0000_07FF);
    apb(1'h1, cmf_pkg::OFS_MASK_L, 32'hE000_0123);
    chkr(cmf_pkg::OFS_MASK_S, 32'h0000_0123);
    apb(1'h1, cmf_pkg::OFS_PRIO, 32'h0000_00FF);
    chkr(cmf_pkg::OFS_PRIO, 32'h0000_001F);
    $display("test storage done");
    // Random filter and mask; low id bits vary so about half pass
    ctrl(1'h0, 1'h1, 1'h0, 1'h0, 2'h0);
    filt = 29'($random(seed)) & 29'h7FF;
    mask = 29'($random(seed)) & 29'h7FF;
    apb(1'h1, cmf_pkg::OFS_FILT_S, 32'(filt));
    apb(1'h1, cmf_pkg::OFS_MASK_S, 32'(mask));
    repeat (24) begin
      id = filt ^ (29'($random(seed)) & 29'h00F);
      dlc = 4'h1 + 4'($random(seed) & 7);
      d = {$random(seed), $random(seed)};
      rx(id, 1'h0, dlc, d);
    end
    repeat (8) @(posedge pclk);
    apb(1'h0, cmf_pkg::OFS_COUNT, 32'h0);
    `CHK(rd, {drops[15:0], 16'(24 - drops)})
    mask = 29'h0;
    apb(1'h1, cmf_pkg::OFS_MASK_L, 32'h0);
    ecu.txq.delete(); // Replies to random First Frames
    $display("test filtering done");
    d = 64'h1014_0102_0304_0506; // First Frame, 20 bytes in all
    ctrl(1'h1, 1'h1, 1'h0, 1'h0, 2'h0);
    rx(29'h7E8, 1'h0, 4'h8, 64'h0341_0C1A_F8AA_BBCC);
    rx(29'h7E8, 1'h0, 4'h8, 64'h4500_1122_3344_5566);
    rx(29'h7E8, 1'h1, 4'h0, 64'h0);
    rx(29'h7E8, 1'h0, 4'h8, d);
    txchk({1'h0, 29'h7E0, 64'h3000_0000_0000_0000});
    ctrl(1'h1, 1'h1, 1'h1, 1'h0, 2'h0);
    rx(29'h7E8, 1'h0, 4'h8, 64'h0241_0D00_0000_0000);
    for (int m = 1; m < 4; m++) begin
      ctrl(1'h1, 1'h1, 1'h0, 1'h0, 2'(m));
      rx(29'h7E8, 1'h0, 4'h8, 64'h4500_1122_3344_5566);
      rx(29'h7E8, 1'h0, 4'h8, d);
    end
    ctrl(1'h1, 1'h0, 1'h0, 1'h0, 2'h0);
    rx(29'h7E8, 1'h0, 4'h8, d);
    ctrl(1'h0, 1'h1, 1'h0, 1'h0, 2'h0);
    rx(29'h7E8, 1'h1, 4'h0, 64'h0);
    rx(29'h7E8, 1'h0, 4'h8, d);
    txchk({1'h0, 29'h7E0, 64'h3000_0000_0000_0000});
    repeat (8) @(posedge pclk);
    `CHK(fcs, fc_exp)
    `CHK(q.size(), 0)
    $display("test formatting done");
    apb(1'h1, cmf_pkg::OFS_HDR, 32'h0012_3456);
    hb = {$random(seed), $random(seed)};
    apb(1'h1, cmf_pkg::OFS_TXD_HI, hb[63:32]);
    apb(1'h1, cmf_pkg::OFS_TXD_LO, hb[31:0]);
    for (int i = 0; i < 4; i++) begin
      ecu.stall = i;
      dlc = (i[0]) ? 4'h8 : 4'h3 + 4'(i);
      ln = (dlc > 4'h7) ? 4'h7 : dlc;
      ctrl(i < 2, 1'h1, i[0], i[1] ^ i[0], 2'h0);
      apb(1'h1, cmf_pkg::OFS_TX_CMD, 32'(dlc));
      id = (i[1] ^ i[0]) ? {5'h1F, 24'h12_3456} : 29'h456;
      d = fmt ? {4'h0, ln, hb[63:8]} & mk(ln + 4'h1) : hb & mk(dlc);
      txchk({i[1] ^ i[0], id, d});
    end
    $display("test transmit done");
    give_verdict();
  end
endmodule // testbench
